// [verilog/custom_tx_pulse_words.sv]
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
// Operation
// - Phase one of a mark drives the first word's seven-bit code.
// - Phase two of a mark drives the second word's seven-bit code.
// - Phase three of a mark drives the third word's seven-bit code.
// - Phase four of a mark drives the fourth word's seven-bit code.
// - Converter code is monotonic in the programmed word value.
// - Custom words are used only while the select bit is one.
// - Word bit 6 is phase polarity, one positive, zero negative.
// - Word bits 5 to 0 are unsigned magnitude, 0.1 V per step.
// - With select clear, template codes chosen by build-out drive pulses.
module custom_tx_pulse_words #(
   parameter logic [6:0] TMPL0_P1 = 7'h5e,
   parameter logic [6:0] TMPL0_P2 = 7'h5a,
   parameter logic [6:0] TMPL0_P3 = 7'h1c,
   parameter logic [6:0] TMPL0_P4 = 7'h04,
   parameter logic [6:0] TMPL1_P1 = 7'h58,
   parameter logic [6:0] TMPL1_P2 = 7'h54,
   parameter logic [6:0] TMPL1_P3 = 7'h18,
   parameter logic [6:0] TMPL1_P4 = 7'h03,
   parameter logic [6:0] TMPL2_P1 = 7'h50,
   parameter logic [6:0] TMPL2_P2 = 7'h4c,
   parameter logic [6:0] TMPL2_P3 = 7'h14,
   parameter logic [6:0] TMPL2_P4 = 7'h02,
   parameter logic [6:0] TMPL3_P1 = 7'h48,
   parameter logic [6:0] TMPL3_P2 = 7'h44,
   parameter logic [6:0] TMPL3_P3 = 7'h10,
   parameter logic [6:0] TMPL3_P4 = 7'h01
) (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic [4:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       MARK_PHASE_VALID,
   input  wire logic [1:0] MARK_PHASE,
   input  wire logic [1:0] BUILD_OUT,
   output logic      [6:0] PHASE_AMPLITUDE_CODE,
   output logic            PHASE_POSITIVE,
   output logic      [5:0] PHASE_MAGNITUDE,
   output logic            DRIVE_ACTIVE,
   output logic            CUSTOM_SHAPE_SELECT
);

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0] shape_enable;
   logic [7:0] next_shape_enable;
   logic [7:0] word [4];
   logic [7:0] next_word [4];
   logic [7:0] next_rdata;
   logic       custom_shape_select;

   assign custom_shape_select =
      shape_enable[pulse_words_pkg::SHAPE_SELECT_BIT];

   always_comb begin
      next_shape_enable = shape_enable;
      if (WR && ADDR == pulse_words_pkg::SHAPE_ENABLE_OFF) begin
         next_shape_enable = WDATA;
      end
   end

   // Words load on their own address only, never on select changes
   for (genvar i = 0; i < 4; i++) begin : g_word
      always_comb begin
         next_word[i] = word[i];
         if (WR && ADDR == pulse_words_pkg::PHASE1_OFF + 5'(i)) begin
            // Bit 7 stored as written; software keeps it clear
            next_word[i] = WDATA;
         end
      end
      always_ff @(posedge CLK) begin
         if (RST) begin
            word[i] <= pulse_words_pkg::PHASE_WORD_RST;
         end else begin
            word[i] <= next_word[i];
         end
      end
   end

   // Read data only in the cycle after the strobe, zero otherwise
   always_comb begin
      next_rdata = 8'h00;
      if (RD) begin
         unique case (ADDR)
            pulse_words_pkg::SHAPE_ENABLE_OFF: next_rdata = shape_enable;
            pulse_words_pkg::PHASE1_OFF:       next_rdata = word[0];
            pulse_words_pkg::PHASE2_OFF:       next_rdata = word[1];
            pulse_words_pkg::PHASE3_OFF:       next_rdata = word[2];
            pulse_words_pkg::PHASE4_OFF:       next_rdata = word[3];
            default:                           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         shape_enable <= pulse_words_pkg::SHAPE_ENABLE_RST;
         RDATA        <= 8'h00;
      end else begin
         shape_enable <= next_shape_enable;
         RDATA        <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter code per mark phase

   logic [6:0] tmpl [16];
   logic [6:0] next_code;
   logic       next_active;

   // Index is build-out set times four plus phase
   assign tmpl = '{TMPL0_P1, TMPL0_P2, TMPL0_P3, TMPL0_P4,
                   TMPL1_P1, TMPL1_P2, TMPL1_P3, TMPL1_P4,
                   TMPL2_P1, TMPL2_P2, TMPL2_P3, TMPL2_P4,
                   TMPL3_P1, TMPL3_P2, TMPL3_P3, TMPL3_P4};

   always_comb begin
      next_code   = 7'h00;
      next_active = 1'b0;
      if (MARK_PHASE_VALID) begin
         next_active = 1'b1;
         if (custom_shape_select) begin
            // Word passed unchanged, so within one polarity a larger value means larger drive
            next_code = word[MARK_PHASE][6:0];
         end else begin
            next_code = tmpl[{BUILD_OUT, MARK_PHASE}];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         // Converter sees a registered code, never a decode glitch
         PHASE_AMPLITUDE_CODE <= 7'h00;
         PHASE_POSITIVE       <= 1'b0;
         PHASE_MAGNITUDE      <= 6'h00;
         DRIVE_ACTIVE         <= 1'b0;
         CUSTOM_SHAPE_SELECT  <= 1'b0;
      end else begin
         PHASE_AMPLITUDE_CODE <= next_code;
         PHASE_POSITIVE       <= next_code[pulse_words_pkg::SIGN_BIT];
         PHASE_MAGNITUDE      <= next_code[5:0];
         DRIVE_ACTIVE         <= next_active;
         CUSTOM_SHAPE_SELECT  <= custom_shape_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence custom_phase_s;
      MARK_PHASE_VALID && custom_shape_select;
   endsequence

   sequence tmpl_phase_s;
      MARK_PHASE_VALID && !custom_shape_select;
   endsequence

   custom_phase1_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s ##0 (MARK_PHASE == 2'h0) |=>
      PHASE_AMPLITUDE_CODE == $past(word[0][6:0]))
      else $error("phase one code mismatch");
   custom_phase2_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s ##0 (MARK_PHASE == 2'h1) |=>
      PHASE_AMPLITUDE_CODE == $past(word[1][6:0]))
      else $error("phase two code mismatch");
   custom_phase3_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s ##0 (MARK_PHASE == 2'h2) |=>
      PHASE_AMPLITUDE_CODE == $past(word[2][6:0]))
      else $error("phase three code mismatch");
   custom_phase4_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s ##0 (MARK_PHASE == 2'h3) |=>
      PHASE_AMPLITUDE_CODE == $past(word[3][6:0]))
      else $error("phase four code mismatch");
   code_split_a: assert property (@(posedge CLK) disable iff (RST)
      PHASE_AMPLITUDE_CODE == {PHASE_POSITIVE, PHASE_MAGNITUDE})
      else $error("code fields disagree");
   select_gate_a: assert property (@(posedge CLK) disable iff (RST)
      tmpl_phase_s |=>
      PHASE_AMPLITUDE_CODE == tmpl[{$past(BUILD_OUT), $past(MARK_PHASE)}])
      else $error("custom word used while deselected");
   sign_bit_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s |=>
      PHASE_POSITIVE == $past(word[MARK_PHASE][6]))
      else $error("polarity wrong");
   idle_zero_a: assert property (@(posedge CLK) disable iff (RST)
      !MARK_PHASE_VALID |=> !DRIVE_ACTIVE && PHASE_MAGNITUDE == 6'h00)
      else $error("drive outside a mark");
   word_hold_a: assert property (@(posedge CLK) disable iff (RST)
      !(WR && ADDR == pulse_words_pkg::PHASE1_OFF) |=> $stable(word[0]))
      else $error("word changed without write");

   ////////////////////////////////////////////////////////////////////////
   // Register side checks

   sequence shape_write_s;
      WR && ADDR == pulse_words_pkg::SHAPE_ENABLE_OFF;
   endsequence

   // Strobes never overlap, so a read is a read alone
   sequence reg_read_s;
      RD && !WR;
   endsequence

   // One set per word, since each word decodes its own offset
   for (genvar k = 0; k < 4; k++) begin : g_word_chk
      sequence word_write_s;
         WR && ADDR == pulse_words_pkg::PHASE1_OFF + 5'(k);
      endsequence

      word_load_a: assert property (@(posedge CLK) disable iff (RST)
         word_write_s |=> word[k] == $past(WDATA))
         else $error("pulse word not loaded");
      word_keep_a: assert property (@(posedge CLK) disable iff (RST)
         !(WR && ADDR == pulse_words_pkg::PHASE1_OFF + 5'(k)) |=>
         $stable(word[k]))
         else $error("pulse word changed without write");
      word_read_a: assert property (@(posedge CLK) disable iff (RST)
         reg_read_s ##0 (ADDR == pulse_words_pkg::PHASE1_OFF + 5'(k)) |=>
         RDATA == $past(word[k]))
         else $error("pulse word read back wrong");
      word_reset_a: assert property (@(posedge CLK)
         RST |=> word[k] == pulse_words_pkg::PHASE_WORD_RST)
         else $error("pulse word not cleared by reset");
   end

   shape_load_a: assert property (@(posedge CLK) disable iff (RST)
      shape_write_s |=> shape_enable == $past(WDATA))
      else $error("enable register not loaded");
   shape_keep_a: assert property (@(posedge CLK) disable iff (RST)
      !(WR && ADDR == pulse_words_pkg::SHAPE_ENABLE_OFF) |=>
      $stable(shape_enable))
      else $error("enable register changed without write");
   shape_read_a: assert property (@(posedge CLK) disable iff (RST)
      reg_read_s ##0 (ADDR == pulse_words_pkg::SHAPE_ENABLE_OFF) |=>
      RDATA == $past(shape_enable))
      else $error("enable register read back wrong");
   shape_reset_a: assert property (@(posedge CLK)
      RST |=> shape_enable == pulse_words_pkg::SHAPE_ENABLE_RST)
      else $error("enable register not reset");

   // Idle bus reads zero so a stray capture never sees old data
   read_idle_a: assert property (@(posedge CLK) disable iff (RST)
      !RD |=> RDATA == 8'h00)
      else $error("read data outside a read");
   select_copy_a: assert property (@(posedge CLK) disable iff (RST)
      1'b1 |=> CUSTOM_SHAPE_SELECT == $past(custom_shape_select))
      else $error("select output lags wrongly");

   ////////////////////////////////////////////////////////////////////////
   // Drive side checks

   sequence mark_s;
      MARK_PHASE_VALID;
   endsequence

   active_follow_a: assert property (@(posedge CLK) disable iff (RST)
      mark_s |=> DRIVE_ACTIVE)
      else $error("drive missing in a mark");
   idle_code_a: assert property (@(posedge CLK) disable iff (RST)
      !MARK_PHASE_VALID |=> PHASE_AMPLITUDE_CODE == 7'h00)
      else $error("converter code outside a mark");
   positive_idle_a: assert property (@(posedge CLK) disable iff (RST)
      !MARK_PHASE_VALID |=> !PHASE_POSITIVE)
      else $error("polarity set outside a mark");
   magnitude_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s |=> PHASE_MAGNITUDE == $past(word[MARK_PHASE][5:0]))
      else $error("magnitude wrong");

   // Custom marks drive even with an all-zero word
   custom_mark_a: assert property (@(posedge CLK) disable iff (RST)
      custom_phase_s |=> DRIVE_ACTIVE)
      else $error("custom mark not driven");

   // Template path must ignore the custom words entirely
   tmpl_sign_a: assert property (@(posedge CLK) disable iff (RST)
      tmpl_phase_s |=>
      PHASE_POSITIVE == $past(tmpl[{BUILD_OUT, MARK_PHASE}][6]))
      else $error("template polarity wrong");
   tmpl_mag_a: assert property (@(posedge CLK) disable iff (RST)
      tmpl_phase_s |=>
      PHASE_MAGNITUDE == $past(tmpl[{BUILD_OUT, MARK_PHASE}][5:0]))
      else $error("template magnitude wrong");

   // Reset must silence the line driver by the next clock edge
   reset_out_a: assert property (@(posedge CLK)
      RST |=> !DRIVE_ACTIVE && RDATA == 8'h00 &&
      PHASE_AMPLITUDE_CODE == 7'h00)
      else $error("outputs not cleared by reset");

endmodule

// [verilog/pulse_words_pkg.sv]
package pulse_words_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int CODE_W = 7;
   localparam int MAG_W  = 6;
   localparam int TMPL_W = 2;
   // Register offsets
   localparam logic [4:0] SHAPE_ENABLE_OFF = 5'h11;
   localparam logic [4:0] PHASE1_OFF       = 5'h1c;
   localparam logic [4:0] PHASE2_OFF       = 5'h1d;
   localparam logic [4:0] PHASE3_OFF       = 5'h1e;
   localparam logic [4:0] PHASE4_OFF       = 5'h1f;
   // Field positions
   localparam int SHAPE_SELECT_BIT = 3;
   localparam int SIGN_BIT         = 6;
   localparam int RESERVED_BIT     = 7;
   // Reset values
   localparam logic [7:0] SHAPE_ENABLE_RST = 8'h80;
   localparam logic [7:0] PHASE_WORD_RST   = 8'h00;
   // Amplitude weight per magnitude step, millivolts
   localparam int STEP_MV = 100;
endpackage

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      logic       cust;
      logic [1:0] bo;
      logic [1:0] ph;
      logic [6:0] code;
   } row_t;
   logic       CLK = 1'b0;
   logic       RST = 1'b1;
   logic [4:0] ADDR = 5'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic       MARK_PHASE_VALID = 1'b0;
   logic [1:0] MARK_PHASE = 2'h0;
   logic [1:0] BUILD_OUT = 2'h0;
   logic [7:0] RDATA;
   logic [6:0] PHASE_AMPLITUDE_CODE;
   logic       PHASE_POSITIVE;
   logic [5:0] PHASE_MAGNITUDE;
   logic       DRIVE_ACTIVE;
   logic       CUSTOM_SHAPE_SELECT;
   int         failures = 0;
   int         check_count = 0;
   int         cycles = 0;
   // Bit 7 kept clear in every word
   logic [7:0] words [4] = '{8'h45, 8'h3f, 8'h01, 8'h7e};
   // Template rows first, custom rows after, then template again
   row_t       rows [13] = '{
      '{1'b0,2'h0,2'h0,7'h5e}, '{1'b0,2'h0,2'h1,7'h5a},
      '{1'b0,2'h0,2'h2,7'h1c}, '{1'b0,2'h0,2'h3,7'h04},
      '{1'b0,2'h3,2'h0,7'h48}, '{1'b0,2'h3,2'h3,7'h01},
      '{1'b0,2'h1,2'h2,7'h18}, '{1'b0,2'h2,2'h1,7'h4c},
      '{1'b1,2'h2,2'h0,7'h45}, '{1'b1,2'h0,2'h1,7'h3f},
      '{1'b1,2'h1,2'h2,7'h01}, '{1'b1,2'h3,2'h3,7'h7e},
      '{1'b0,2'h1,2'h3,7'h03}};
   always #2 CLK = ~CLK;
   custom_tx_pulse_words dut (.CLK(CLK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .MARK_PHASE_VALID(MARK_PHASE_VALID), .MARK_PHASE(MARK_PHASE),
      .BUILD_OUT(BUILD_OUT), .PHASE_AMPLITUDE_CODE(PHASE_AMPLITUDE_CODE),
      .PHASE_POSITIVE(PHASE_POSITIVE), .PHASE_MAGNITUDE(PHASE_MAGNITUDE),
      .DRIVE_ACTIVE(DRIVE_ACTIVE), .CUSTOM_SHAPE_SELECT(CUSTOM_SHAPE_SELECT));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_code(string n, logic [6:0] e, logic [6:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1; ADDR <= a; WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(logic [4:0] a, logic [7:0] e);
      @(posedge CLK);
      RD <= 1'b1; ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk_reg("rdata", e, RDATA);
   endtask
   task automatic drive(logic [1:0] bo, logic [1:0] ph, logic [6:0] e);
      @(posedge CLK);
      MARK_PHASE_VALID <= 1'b1; MARK_PHASE <= ph; BUILD_OUT <= bo;
      @(posedge CLK);
      MARK_PHASE_VALID <= 1'b0;
      #1 chk_code("code", e, PHASE_AMPLITUDE_CODE);
      chk_code("sign", {6'h00, e[6]}, {6'h00, PHASE_POSITIVE});
      chk_code("mag", {1'b0, e[5:0]}, {1'b0, PHASE_MAGNITUDE});
      chk_code("active", 7'h01, {6'h00, DRIVE_ACTIVE});
      @(posedge CLK);
      #1 chk_code("idle", 7'h00, PHASE_AMPLITUDE_CODE);
   endtask
   task automatic reset_check();
      rd(pulse_words_pkg::SHAPE_ENABLE_OFF, 8'h80);
      for (int i = 0; i < 4; i++) begin
         rd(pulse_words_pkg::PHASE1_OFF + 5'(i), 8'h00);
      end
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Ceiling well above the roughly 160 cycles the run needs
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      reset_check();
      // Loaded while templates drive, so enabling uses them later
      for (int i = 0; i < 4; i++) begin
         wr(pulse_words_pkg::PHASE1_OFF + 5'(i), words[i]);
      end
      for (int i = 0; i < 4; i++) begin
         rd(pulse_words_pkg::PHASE1_OFF + 5'(i), words[i]);
      end
      foreach (rows[i]) begin
         wr(pulse_words_pkg::SHAPE_ENABLE_OFF, rows[i].cust ? 8'h88 : 8'h80);
         repeat (2) @(posedge CLK);
         #1 chk_code("select", {6'h00, rows[i].cust},
                     {6'h00, CUSTOM_SHAPE_SELECT});
         drive(rows[i].bo, rows[i].ph,
               rows[i].code);
      end
      // Unmapped place: write ignored, read gives zero
      wr(5'h05, 8'hff);
      rd(5'h05, 8'h00);
      // Back to back write then read, larger code gives larger magnitude
      wr(pulse_words_pkg::PHASE1_OFF, 8'h46);
      rd(pulse_words_pkg::PHASE1_OFF, 8'h46);
      wr(pulse_words_pkg::SHAPE_ENABLE_OFF, 8'h88);
      repeat (2) @(posedge CLK);
      drive(2'h0, 2'h0, 7'h46);
      // Reset in mid-run clears words and select
      @(posedge CLK);
      RST <= 1'b1;
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      #1 chk_code("select", 7'h00, {6'h00, CUSTOM_SHAPE_SELECT});
      reset_check();
      summarize();
   end
endmodule
